/* rtl/backup_charge_scheduler.sv */
// Backup cell charge scheduler with AXI4-Lite registers.
// Assumes a 256 Hz clock pin, a handshaked 10-bit temperature converter and
// an analog comparator that flags when the cell sits above the target.
module backup_charge_scheduler #(
  parameter int STARTUP_CYCLES = chg_pkg::STARTUP_CYC,
  parameter int INIT_SECS      = chg_pkg::INIT_HOURS_MIN * chg_pkg::SECS_PER_HOUR,
  parameter int HOUR_SECS      = chg_pkg::SECS_PER_HOUR,
  parameter int MIN_SECS       = chg_pkg::SECS_PER_MIN
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // AXI4-Lite write
  input wire logic [4:0]  awaddr,
  input wire logic        awvalid,
  output logic            awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  output logic            wready,
  output logic [1:0]      bresp,
  output logic            bvalid,
  input wire logic        bready,
  // AXI4-Lite read
  input wire logic [4:0]  araddr,
  input wire logic        arvalid,
  output logic            arready,
  output logic [31:0]     rdata,
  output logic [1:0]      rresp,
  output logic            rvalid,
  input wire logic        rready,
  // Pins
  input wire logic        lf_clk_in,
  input wire logic        adc_done,
  input wire logic [9:0]  adc_data,
  input wire logic        batt_above_target,
  output logic            adc_start,
  output logic            backup_charge_en,
  output logic            backup_sink_en,
  output logic [3:0]      comp_step
);
  typedef enum logic [2:0] {ST_WAIT, ST_MEAS, ST_LOCK, ST_INIT, ST_ON, ST_OFF} state_e;
  state_e st_r;
  logic [2:0]  lf_sync_r;
  logic [1:0]  done_sync_r, batt_sync_r;
  logic [9:0]  data_m_r, data_s_r;
  logic [7:0]  lf_cnt_r;
  logic        sec_tick_r;
  logic [22:0] wait_cnt_r;
  logic [1:0]  freq_sel_r;
  logic        hot_sel_r, sw_meas_r, adc_busy_r, res_new_r, init_done_r, lock_wait_r;
  logic        cyc_start_r, on_start_r, cyc_done, on_done;
  logic [9:0]  temp_result_r, lock_hours_r;
  logic [7:0]  lock_min_r;
  logic [21:0] cyc_limit_r, on_limit_r;
  logic        wr_go, force_wr, meas_wr, rd_go, start_conv;
  logic [31:0] rd_val;
  temp_map_if  tm ();

  // ----------------------------------------------------------------
  // Pin synchronisers and 1 s tick from the slow clock
  // ----------------------------------------------------------------
  // Two stages per pin; the third lf stage only serves the edge detector.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_sync_r   <= 3'h0;
      done_sync_r <= 2'h0;
      batt_sync_r <= 2'h0;
      data_m_r    <= 10'h000;
      data_s_r    <= 10'h000;
    end else begin
      lf_sync_r   <= {lf_sync_r[1:0], lf_clk_in};
      done_sync_r <= {done_sync_r[0], adc_done};
      batt_sync_r <= {batt_sync_r[0], batt_above_target};
      data_m_r    <= adc_data;
      data_s_r    <= data_m_r;
    end
  end

  // Cycle and on-time timing comes from the timekeeping clock; the startup delay counts bus clocks.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_cnt_r   <= 8'h00;
      sec_tick_r <= 1'b0;
    end else begin
      sec_tick_r <= 1'b0;
      if (lf_sync_r[1] && !lf_sync_r[2]) begin
        lf_cnt_r <= lf_cnt_r + 8'h01;
        sec_tick_r <= lf_cnt_r == 8'(chg_pkg::LF_EDGES_PER_SEC - 1);
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Ready is raised only with both address and data present, so either
  // arrival order works; one write and one read are in flight at most.
  assign wr_go    = awvalid && wvalid && !awready && !bvalid;
  assign rd_go    = arvalid && !arready && !rvalid;
  assign force_wr = wr_go && awaddr == chg_pkg::REG_COMMAND && wstrb[0]
                    && wdata[chg_pkg::CMD_FORCE_BIT];
  assign meas_wr  = wr_go && awaddr == chg_pkg::REG_COMMAND && wstrb[0]
                    && wdata[chg_pkg::CMD_MEAS_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= chg_pkg::RESP_OKAY;
    end else begin
      awready <= wr_go;
      wready  <= wr_go;
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= (awaddr == chg_pkg::REG_CONFIG || awaddr == chg_pkg::REG_COMMAND ||
                   awaddr == chg_pkg::REG_TEMP || awaddr == chg_pkg::REG_STATUS) ?
                  chg_pkg::RESP_OKAY : chg_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Configuration is only cleared by the supply reset, never by a forced restart.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {hot_sel_r, freq_sel_r} <= chg_pkg::CONFIG_RST;
    end else if (wr_go && awaddr == chg_pkg::REG_CONFIG && wstrb[0]) begin
      freq_sel_r <= wdata[1:0];
      hot_sel_r  <= wdata[chg_pkg::CFG_HOT_BIT];
    end
  end

  always_comb begin
    rd_val = 32'h00000000;
    unique case (araddr)
      chg_pkg::REG_CONFIG:  rd_val = {29'h0, hot_sel_r, freq_sel_r};
      chg_pkg::REG_COMMAND: rd_val = {30'h0, sw_meas_r, 1'b0};
      chg_pkg::REG_TEMP:    rd_val = {22'h0, temp_result_r};
      chg_pkg::REG_STATUS:  rd_val = {21'h0, adc_busy_r, comp_step, backup_sink_en,
                                      backup_charge_en, init_done_r, st_r};
      default:              rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= chg_pkg::RESP_OKAY;
    end else begin
      arready <= rd_go;
      if (rd_go) begin
        rvalid <= 1'b1;
        rdata  <= rd_val;
        rresp  <= (araddr[4] || araddr[1:0] != 2'h0) ?
                  chg_pkg::RESP_SLVERR : chg_pkg::RESP_OKAY;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Temperature conversion
  // ----------------------------------------------------------------
  assign start_conv = !adc_busy_r && !done_sync_r[1] && (sw_meas_r || st_r == ST_MEAS);

  // A software request arriving as a conversion starts is kept: set wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_meas_r <= 1'b0;
    end else if (meas_wr) begin
      sw_meas_r <= 1'b1;
    end else if (start_conv) begin
      sw_meas_r <= 1'b0;
    end
  end

  // Start is held until the converter reports done; data is taken then.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_busy_r    <= 1'b0;
      adc_start     <= 1'b0;
      res_new_r     <= 1'b0;
      temp_result_r <= 10'h000;
    end else begin
      res_new_r <= 1'b0;
      if (start_conv) begin
        adc_busy_r <= 1'b1;
        adc_start  <= 1'b1;
      end else if (adc_busy_r && done_sync_r[1]) begin
        adc_busy_r    <= 1'b0;
        adc_start     <= 1'b0;
        temp_result_r <= data_s_r;
        res_new_r     <= 1'b1;
      end
    end
  end

  // Compensation follows every new reading at once, mid-cycle included.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comp_step <= 4'h0;
    end else if (temp_result_r <= chg_pkg::CODE_25C) begin
      comp_step <= 4'h0;
    end else if (temp_result_r >= chg_pkg::CODE_85C) begin
      comp_step <= chg_pkg::STEP_MAX;
    end else begin
      comp_step <= 4'((temp_result_r - chg_pkg::CODE_25C + chg_pkg::STEP_ROUND) >> 4);
    end
  end

  // ----------------------------------------------------------------
  // Scheduler
  // ----------------------------------------------------------------
  assign tm.freq_sel = freq_sel_r;
  assign tm.hot_sel  = hot_sel_r;
  assign tm.warm     = temp_result_r > chg_pkg::CODE_25C;
  assign tm.hot      = temp_result_r >= chg_pkg::CODE_40C;

  temp_map u_map (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tm      (tm.lookup)
  );

  sec_timer u_cyc (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (cyc_start_r),
    .sec_tick (sec_tick_r),
    .limit    (cyc_limit_r),
    .done     (cyc_done)
  );

  sec_timer u_on (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .start    (on_start_r),
    .sec_tick (sec_tick_r),
    .limit    (on_limit_r),
    .done     (on_done)
  );

  // A forced recharge acts as an internal power-on event from any state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r        <= ST_WAIT;
      wait_cnt_r  <= 23'h000000;
      init_done_r <= 1'b0;
      lock_wait_r <= 1'b0;
      cyc_start_r <= 1'b0;
      on_start_r  <= 1'b0;
      cyc_limit_r <= 22'h000000;
      on_limit_r  <= 22'h000000;
      lock_hours_r <= 10'h000;
      lock_min_r  <= 8'h00;
    end else begin
      cyc_start_r <= 1'b0;
      on_start_r  <= 1'b0;
      if (force_wr) begin
        st_r        <= ST_WAIT;
        wait_cnt_r  <= 23'h000000;
        init_done_r <= 1'b0;
      end else begin
        unique case (st_r)
          ST_WAIT: begin
            wait_cnt_r <= wait_cnt_r + 23'h000001;
            if (wait_cnt_r == 23'(STARTUP_CYCLES - 1)) st_r <= ST_MEAS;
          end
          ST_MEAS: if (res_new_r) begin
            st_r        <= ST_LOCK;
            lock_wait_r <= 1'b0;
          end
          ST_LOCK: begin
            // The table answers one cycle after the new reading settles.
            lock_wait_r <= 1'b1;
            if (lock_wait_r) begin
              lock_hours_r <= tm.interval_hours;
              lock_min_r   <= tm.on_minutes;
              cyc_start_r  <= 1'b1;
              if (!init_done_r) begin
                cyc_limit_r <= 22'(INIT_SECS);
                st_r        <= ST_INIT;
              end else begin
                cyc_limit_r <= 22'(tm.interval_hours * HOUR_SECS);
                on_limit_r  <= 22'(tm.on_minutes * MIN_SECS);
                on_start_r  <= 1'b1;
                st_r        <= ST_ON;
              end
            end
          end
          ST_INIT: if (cyc_done && !cyc_start_r) begin
            init_done_r <= 1'b1;
            st_r        <= ST_MEAS;
          end
          ST_ON: if (on_done && !on_start_r) st_r <= ST_OFF;
          ST_OFF: if (cyc_done) st_r <= ST_MEAS;
        endcase
      end
    end
  end

  // Drive or sink only during the initial charge and the on-time; sink when the cell sits high.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      backup_charge_en <= 1'b0;
      backup_sink_en   <= 1'b0;
    end else begin
      backup_charge_en <= (st_r == ST_INIT || st_r == ST_ON) && !batt_sync_r[1];
      backup_sink_en   <= (st_r == ST_INIT || st_r == ST_ON) && batt_sync_r[1];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_startup_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_WAIT && !force_wr && wait_cnt_r < 23'(STARTUP_CYCLES - 1) |=> st_r == ST_WAIT)
    else $error("startup delay ended early");
  chk_force_reboot: assert property (@(posedge aclk) disable iff (!aresetn)
    force_wr |=> st_r == ST_WAIT && !init_done_r)
    else $error("forced recharge did not restart");
  chk_lock_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ST_ON || st_r == ST_OFF) |=> $stable(lock_hours_r) && $stable(cyc_limit_r))
    else $error("locked interval changed mid-cycle");
  chk_midcycle_meas: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ST_INIT || st_r == ST_ON || st_r == ST_OFF) && res_new_r |=> $stable(lock_min_r)
    && $stable(on_limit_r))
    else $error("mid-cycle reading changed on-time");
  chk_cycle_measure: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_OFF && cyc_done && !force_wr |=> st_r == ST_MEAS ##1 adc_busy_r || $past(adc_busy_r))
    else $error("cycle start without measurement");
  chk_init_charge: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == ST_INIT && !batt_sync_r[1] |=> backup_charge_en)
    else $error("initial charge not driven");
  chk_sink_window: assert property (@(posedge aclk) disable iff (!aresetn)
    backup_sink_en |-> $past(st_r == ST_INIT || st_r == ST_ON) && $past(batt_sync_r[1]))
    else $error("sink outside on-time");
  chk_result_store: assert property (@(posedge aclk) disable iff (!aresetn)
    adc_busy_r && done_sync_r[1] && !start_conv |=> temp_result_r == $past(data_s_r) && res_new_r)
    else $error("temperature result not stored");
  chk_cold_target: assert property (@(posedge aclk) disable iff (!aresetn)
    temp_result_r <= chg_pkg::CODE_25C |=> comp_step == 4'h0)
    else $error("compensation applied at or below 25C");
  chk_meas_request: assert property (@(posedge aclk) disable iff (!aresetn)
    meas_wr |=> sw_meas_r || adc_busy_r)
    else $error("measure request lost");
endmodule // backup_charge_scheduler

/* rtl/chg_pkg.sv */
// Constants shared by the backup charge scheduler and its helper modules.
// Assumes a 125 MHz bus clock and a free-running 256 Hz timekeeping clock.
// Function
// - Charge continuously 72 to 96 hours first.
// - Then start refresh charge cycles periodically.
// - Interval from frequency select, hot step-up.
// - Interval and on-time locked per cycle.
// - Force recharge restarts from initial charge.
// - Lower target in 4 degree steps above 25.
// - Sink current when target below battery.
// - Store 10-bit temperature result readable.
// - Measure temperature at every cycle start.
// - Interval sets delay to next cycle.
// - Measure request updates result and compensation.
// - Mid-cycle reading leaves interval, on-time alone.
// - Controller starts about 40 ms after start.
// - Configuration survives an internal restart.
package chg_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ          = 125000;
  localparam int STARTUP_MS       = 40;
  localparam int STARTUP_CYC      = STARTUP_MS * CLK_KHZ;
  localparam int LF_EDGES_PER_SEC = 256;
  localparam int INIT_HOURS_MIN   = 72;
  localparam int INIT_HOURS_MAX   = 96;
  localparam int SECS_PER_HOUR    = 3600;
  localparam int SECS_PER_MIN     = 60;
  localparam int TIMER_W          = 22;
  // ----------------------------------------------------------------
  // Temperature coding: code = (degC + offset) * 4.
  // ----------------------------------------------------------------
  localparam int TEMP_OFFS_C = 40;
  localparam int CODES_PER_C = 4;
  localparam int STEP_C      = 4;
  localparam logic [9:0] CODE_25C = 10'((25 + TEMP_OFFS_C) * CODES_PER_C);
  localparam logic [9:0] CODE_40C = 10'((40 + TEMP_OFFS_C) * CODES_PER_C);
  localparam logic [9:0] CODE_85C = 10'((85 + TEMP_OFFS_C) * CODES_PER_C);
  localparam logic [9:0] STEP_ROUND = 10'(STEP_C * CODES_PER_C - 1);
  localparam logic [3:0] STEP_MAX   = 4'((85 - 25) / STEP_C);
  // ----------------------------------------------------------------
  // Interval (hours) and on-time (minutes) table.
  // ----------------------------------------------------------------
  localparam logic [9:0] INTV_HOURS [4] = '{10'h300, 10'h0A8, 10'h018, 10'h004};
  localparam logic [7:0] ON_MIN_COLD = 8'h3C;
  localparam logic [7:0] ON_MIN_WARM = 8'h1E;
  localparam logic [7:0] ON_MIN_HOT  = 8'h0F;
  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CONFIG  = 5'h00;
  localparam logic [4:0] REG_COMMAND = 5'h04;
  localparam logic [4:0] REG_TEMP    = 5'h08;
  localparam logic [4:0] REG_STATUS  = 5'h0C;
  localparam logic [2:0] CONFIG_RST  = 3'h0;
  localparam int CFG_HOT_BIT   = 2;
  localparam int CMD_FORCE_BIT = 0;
  localparam int CMD_MEAS_BIT  = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* rtl/temp_map_if.sv */
// Lookup request and answer between the scheduler and its table.
// Assumes both ends run on the same clock.
interface temp_map_if;
  logic [1:0] freq_sel;
  logic       hot_sel;
  logic       warm;
  logic       hot;
  logic [9:0] interval_hours;
  logic [7:0] on_minutes;
  modport lookup (input freq_sel, hot_sel, warm, hot, output interval_hours, on_minutes);
  modport user   (output freq_sel, hot_sel, warm, hot, input interval_hours, on_minutes);
endinterface

/* rtl/temp_map.sv */
// Temperature and setting to interval and on-time table, registered output.
// Assumes inputs are stable for one cycle before the answer is used.
module temp_map (
  // Clock and reset
  input wire logic      aclk,
  input wire logic      aresetn,
  // Lookup
  temp_map_if.lookup    tm
);
  logic [1:0] idx;
  // Hot step-up moves one row towards more frequent charging.
  always_comb begin
    idx = tm.freq_sel;
    if (tm.hot && tm.hot_sel && tm.freq_sel != 2'h3) begin
      idx = tm.freq_sel + 2'h1;
    end
  end
  // Table read lands in a register, as a small memory would.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tm.interval_hours <= chg_pkg::INTV_HOURS[0];
      tm.on_minutes     <= chg_pkg::ON_MIN_COLD;
    end else begin
      tm.interval_hours <= chg_pkg::INTV_HOURS[idx];
      tm.on_minutes     <= tm.hot ? chg_pkg::ON_MIN_HOT :
                           (tm.warm ? chg_pkg::ON_MIN_WARM : chg_pkg::ON_MIN_COLD);
    end
  end
endmodule // temp_map

/* rtl/sec_timer.sv */
// Seconds counter with a loadable limit and a sticky done level.
// Assumes sec_tick is a one-cycle pulse once per second.
module sec_timer (
  // Clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Control
  input wire logic                       start,
  input wire logic                       sec_tick,
  input wire logic [chg_pkg::TIMER_W-1:0] limit,
  output logic                           done
);
  logic [chg_pkg::TIMER_W-1:0] cnt_r;
  // A start clears both count and done, so a restart never sees a stale finish.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      done  <= 1'b0;
    end else if (start) begin
      cnt_r <= '0;
      done  <= 1'b0;
    end else if (sec_tick && !done) begin
      cnt_r <= cnt_r + 1'b1;
      // One tick past the limit, so a part second at start never shortens a period.
      done  <= (cnt_r + 1'b1) > limit;
    end
  end
endmodule // sec_timer

/* bench/cell_model.sv */
// Far side of the scheduler: temperature converter and backup cell comparator.
// Assumes the bench sets the die temperature code, converter lag and cell level.
module cell_model (
  // Clock
  input wire logic       aclk,
  // Converter
  input wire logic       adc_start,
  input wire logic [9:0] temp_code,
  input wire logic [7:0] lag,
  output logic           adc_done = 1'b0,
  output logic [9:0]     adc_data = 10'h000,
  // Cell
  input wire logic       cell_full,
  output logic           batt_above_target
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_r = 8'h00;

  // The converter answers lag + 1 cycles after start and holds its 10-bit word while done is up.
  // Once released the data lines toggle, so a late sample never sees a stale match.
  always @(posedge aclk) begin
    if (adc_start && !adc_done) begin
      wait_r <= wait_r + 8'h01;
      if (wait_r >= lag) begin
        adc_done <= 1'b1;
        adc_data <= temp_code;
      end
    end else if (!adc_start && adc_done) begin
      adc_done <= 1'b0;
      wait_r   <= 8'h00;
      adc_data <= ~adc_data;
    end else if (!adc_done) begin
      adc_data <= ~adc_data;
    end
  end

  // The cell level is held by the bench, so the comparator is a plain level.
  assign batt_above_target = cell_full;
endmodule // cell_model

/* bench/test_backup_charge_scheduler.sv */
// Self-checking bench for the backup charge scheduler over its register bus.
// Assumes shortened second and startup counts and a fast timekeeping clock.
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_backup_charge_scheduler;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rdv;
  logic [3:0]  wstrb = 4'hF, comp_step;
  logic [1:0]  bresp, rresp, rr;
  logic        awready, wready, bvalid, arready, rvalid, adc_start, adc_done;
  logic        batt_above_target, backup_charge_en, backup_sink_en, cell_full = 1'b0;
  logic [9:0]  adc_data, temp_code = 10'h0F0;
  logic [7:0]  lag = 8'h03;
  logic [1:0]  lf_cnt = 2'h0;
  int          err_total = 0, n_checks = 0, cyc = 0, n, t_a, t_b;
  logic [9:0]  codes [5] = '{10'h0F0, 10'h104, 10'h108, 10'h1F4, 10'h168};
  logic [3:0]  steps [5] = '{4'h0, 4'h0, 4'h1, 4'hF, 4'h7};

  // --------------------------------------------------------------
  // Clocks and instances
  // --------------------------------------------------------------
  // Timekeeping clock runs at a quarter of the bus clock to keep the run short.
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    lf_cnt <= lf_cnt + 2'h1;
    cyc++;
  end

  backup_charge_scheduler #(.STARTUP_CYCLES(20), .INIT_SECS(3), .HOUR_SECS(4), .MIN_SECS(1))
    i_backup_charge_scheduler (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .lf_clk_in(lf_cnt[1]), .adc_done(adc_done), .adc_data(adc_data),
    .batt_above_target(batt_above_target), .adc_start(adc_start),
    .backup_charge_en(backup_charge_en), .backup_sink_en(backup_sink_en),
    .comp_step(comp_step));

  cell_model i_cell_model (.aclk(aclk), .adc_start(adc_start), .temp_code(temp_code),
    .lag(lag), .adc_done(adc_done), .adc_data(adc_data), .cell_full(cell_full),
    .batt_above_target(batt_above_target));

  // --------------------------------------------------------------
  // Bus tasks
  // --------------------------------------------------------------
  // Each channel is released at the edge where its own ready or the response valid is seen, or after 50 edges.
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (awready === 1'b1 || bvalid === 1'b1 || k == 50) awvalid <= 1'b0;
      if (wready === 1'b1 || bvalid === 1'b1 || k == 50) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && k < 50);
    `CHK(bvalid, 1'b1)
    `CHK(bresp, er)
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [4:0] a);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (arready === 1'b1 || rvalid === 1'b1 || k == 50) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && k < 50);
    `CHK(rvalid, 1'b1)
    rdv = rdata;
    rr = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Polling stops on a match or after a bounded number of reads.
  task automatic poll(input logic [4:0] a, input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do begin
      rd(a);
      k++;
    end while ((rdv & m) !== v && k < 4000);
    `CHK(rdv & m, v)
  endtask

  task automatic wait_adc(input int lim);
    n = 0;
    while (adc_start !== 1'b1 && n < lim) begin
      @(posedge aclk);
      n++;
    end
    t_a = cyc;
  endtask

  task automatic conclude;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  // Watchdog sized well above the longest cycle the tests wait through.
  initial begin
    repeat (40000) @(posedge aclk);
    err_total++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wait_adc(1000);
    `CHK(n >= 18 && n <= 60, 1'b1)
    rd(chg_pkg::REG_CONFIG);
    `CHK(rdv, 32'h0)
    rd(5'h10);
    `CHK(rr, chg_pkg::RESP_SLVERR)
    `CHK(rdv, 32'h0)
    wr(5'h14, 32'h7, chg_pkg::RESP_SLVERR);
    wr(chg_pkg::REG_CONFIG, 32'hFF, chg_pkg::RESP_OKAY);
    rd(chg_pkg::REG_CONFIG);
    `CHK(rdv, 32'h7)
    wr(chg_pkg::REG_CONFIG, 32'h3, chg_pkg::RESP_OKAY);
    poll(chg_pkg::REG_STATUS, 32'hF, 32'h3);
    `CHK(backup_charge_en, 1'b1)
    // Mid-cycle readings across the compensation range, fast and slow converter.
    for (int i = 0; i < 5; i++) begin
      temp_code <= codes[i];
      lag <= i[0] ? 8'h09 : 8'h00;
      wr(chg_pkg::REG_COMMAND, 32'h2, chg_pkg::RESP_OKAY);
      poll(chg_pkg::REG_COMMAND, 32'h2, 32'h0);
      poll(chg_pkg::REG_STATUS, 32'h400, 32'h0);
      rd(chg_pkg::REG_TEMP);
      `CHK(rdv, {22'h0, codes[i]})
      repeat (2) @(posedge aclk);
      `CHK(comp_step, steps[i])
      rd(chg_pkg::REG_STATUS);
      `CHK(rdv[9:6], steps[i])
      `CHK(rdv[2:0], 3'h3)
    end
    // A slow converter keeps the first refresh measurement running until the wait_adc that follows.
    cell_full <= 1'b1;
    lag <= 8'h40;
    poll(chg_pkg::REG_STATUS, 32'h8, 32'h8);
    `CHK(cyc - t_a >= 2048 && cyc - t_a <= 4300, 1'b1)
    t_a = cyc;
    wait_adc(20000);
    `CHK(adc_start, 1'b1)
    `CHK(n <= 9400, 1'b1)
    t_b = t_a;
    n = 0;
    while (backup_sink_en !== 1'b1 && n < 500) begin
      @(posedge aclk);
      n++;
    end
    `CHK(backup_sink_en, 1'b1)
    `CHK(backup_charge_en, 1'b0)
    wr(chg_pkg::REG_CONFIG, 32'h4, chg_pkg::RESP_OKAY);
    rd(chg_pkg::REG_STATUS);
    `CHK(rdv[2:0], 3'h4)
    // The write above must not stretch the locked interval of this cycle.
    wait_adc(20000);
    `CHK(adc_start, 1'b1)
    `CHK(t_a - t_b >= 16300 && t_a - t_b <= 17600, 1'b1)
    poll(chg_pkg::REG_STATUS, 32'h407, 32'h004);
    wr(chg_pkg::REG_COMMAND, 32'h1, chg_pkg::RESP_OKAY);
    rd(chg_pkg::REG_STATUS);
    `CHK(rdv[3:0], 4'h0)
    `CHK(backup_sink_en, 1'b0)
    rd(chg_pkg::REG_CONFIG);
    `CHK(rdv, 32'h4)
    wait_adc(200);
    `CHK(adc_start, 1'b1)
    conclude();
  end
endmodule // test_backup_charge_scheduler
